// File: core/ebi_pkg.sv
// Package of constants and types for the external bus pin interface.
`default_nettype none
package ebi_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_CS = 6;
  // ==========================================================
  // Values after reset
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [NUM_CS-1:0] CS_RESET = 6'h00;
  // Bus cycle phases.
  typedef enum logic [1:0] {
    EBI_IDLE,
    EBI_ACCESS,
    EBI_DONE
  } ebi_state_t;
endpackage : ebi_pkg
`default_nettype wire

// File: core/ebi_lane_mux.sv
// Per-data-lane pin multiplexer between the bus and the shared port pin.
`default_nettype none
module ebi_lane_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Lane control
  input wire logic [ebi_pkg::DATA_W-1:0] lane_alt,
  input wire logic [ebi_pkg::DATA_W-1:0] lane_drive,
  input wire logic [ebi_pkg::DATA_W-1:0] lane_out,
  // Port pin fallback
  input wire logic [ebi_pkg::DATA_W-1:0] port_out,
  input wire logic [ebi_pkg::DATA_W-1:0] port_oe,
  // Pins
  output logic [ebi_pkg::DATA_W-1:0] pin_out,
  output logic [ebi_pkg::DATA_W-1:0] pin_oe
);
  import ebi_pkg::*;

  // ==========================================================
  // Lane registers
  // Each lane picks its source alone, so unused lanes stay port pins.
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_lane
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_out[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
        end else if (lane_alt[g]) begin
          pin_out[g] <= lane_out[g];
          pin_oe[g] <= lane_drive[g];
        end else begin
          pin_out[g] <= port_out[g];
          pin_oe[g] <= port_oe[g];
        end
      end
    end
  endgenerate
endmodule : ebi_lane_mux
`default_nettype wire

// File: core/ebi_pins.sv
// Top level of the external bus pin interface.
`default_nettype none
module ebi_pins (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire logic ext_enable,
  input wire logic exec_internal,
  input wire logic bus_16bit,
  input wire logic [ebi_pkg::ADDR_W-1:0] addr_alt_en,
  input wire logic [ebi_pkg::DATA_W-1:0] data_alt_en,
  input wire logic [ebi_pkg::NUM_CS-1:0] cs_active_high,
  // Processor request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ebi_pkg::ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_lanes,
  input wire logic [ebi_pkg::DATA_W-1:0] req_wdata,
  input wire logic [ebi_pkg::NUM_CS-1:0] req_cs,
  // Processor answer
  output logic cpu_stall,
  output logic rsp_valid,
  output logic [ebi_pkg::DATA_W-1:0] rsp_rdata,
  // Shared port pin values
  input wire logic [ebi_pkg::ADDR_W-1:0] port_addr_out,
  input wire logic [ebi_pkg::ADDR_W-1:0] port_addr_oe,
  input wire logic [ebi_pkg::DATA_W-1:0] port_data_out,
  input wire logic [ebi_pkg::DATA_W-1:0] port_data_oe,
  // Address pins
  output logic [ebi_pkg::ADDR_W-1:0] addr_out,
  output logic [ebi_pkg::ADDR_W-1:0] addr_oe,
  // Data pins
  input wire logic [ebi_pkg::DATA_W-1:0] data_in,
  output logic [ebi_pkg::DATA_W-1:0] data_out,
  output logic [ebi_pkg::DATA_W-1:0] data_oe,
  // Strobes
  output logic read_strobe,
  output logic write_strobe,
  output logic [ebi_pkg::NUM_CS-1:0] chip_select_outputs,
  output logic upper_byte_lane_enable,
  output logic lower_byte_lane_enable,
  input wire logic wait_in
);
  import ebi_pkg::*;

  ebi_state_t state_q;
  logic wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0] lanes_q;
  logic [NUM_CS-1:0] cs_q;
  logic [DATA_W-1:0] lane_alt;
  logic [DATA_W-1:0] lane_drive;
  logic active;
  logic take;
  logic busy_d;
  logic wr_d;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_d;
  logic [1:0] lanes_d;
  logic [NUM_CS-1:0] cs_d;

  // ==========================================================
  // Request acceptance
  // A request is taken only in idle, with the interface on and code running outside.
  assign take = (state_q == EBI_IDLE) && req_valid && ext_enable && !exec_internal;
  assign active = (state_q == EBI_ACCESS);
  // Busy from the taking edge until wait is seen low in access.
  assign busy_d = take || (active && wait_in);

  // Next request fields: the taken request, or the one already on the pins.
  // The pins are loaded from these so that the far side sees address, data and
  // strobe together in the first cycle of access, before wait is sampled.
  always_comb begin
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    lanes_d = lanes_q;
    cs_d = cs_q;
    if (take) begin
      wr_d = req_write;
      addr_d = req_addr;
      wdata_d = req_wdata;
      lanes_d = bus_16bit ? req_lanes : 2'h1;
      cs_d = req_cs;
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  // A request is taken only in idle; the processor is stalled until done.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= EBI_IDLE;
    end else begin
      case (state_q)
        EBI_IDLE: begin
          if (take) begin
            state_q <= EBI_ACCESS;
          end
        end
        EBI_ACCESS: begin
          if (!wait_in) begin
            state_q <= EBI_DONE;
          end
        end
        EBI_DONE: state_q <= EBI_IDLE;
        default: state_q <= EBI_IDLE;
      endcase
    end
  end

  // Hold the taken request so the pins stay stable for the whole cycle.
  // A refused request leaves no trace, so idle address pins do not wander.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
      lanes_q <= 2'h0;
      cs_q <= CS_RESET;
    end else begin
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      lanes_q <= lanes_d;
      cs_q <= cs_d;
    end
  end

  // ==========================================================
  // Processor answer
  // Stall rises with the taken request so no second request slips in.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_stall <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RESET;
    end else begin
      cpu_stall <= busy_d;
      rsp_valid <= active && !wait_in;
      // The read strobe has stood for the whole access cycle when data is taken here.
      if (active && !wait_in && !wr_q) begin
        rsp_rdata <= bus_16bit ? data_in : {8'h00, data_in[BYTE_W-1:0]};
      end
    end
  end

  // ==========================================================
  // Address pins
  // Lines not enabled, or any line with the interface off, fall back to the port; enabled lines drive while the interface is on.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_out <= ADDR_RESET;
      addr_oe <= ADDR_RESET;
    end else begin
      for (int i = 0; i < ADDR_W; i++) begin
        if (addr_alt_en[i] && ext_enable) begin
          addr_out[i] <= exec_internal ? 1'b0 : addr_d[i];
          addr_oe[i] <= 1'b1;
        end else begin
          addr_out[i] <= port_addr_out[i];
          addr_oe[i] <= port_addr_oe[i];
        end
      end
    end
  end

  // ==========================================================
  // Strobes
  // Chip selects are inverted per line when programmed active low.
  // Strobes rise with the taking edge and fall with the edge that ends access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
      chip_select_outputs <= CS_RESET;
      upper_byte_lane_enable <= 1'b0;
      lower_byte_lane_enable <= 1'b0;
    end else begin
      read_strobe <= busy_d && !wr_d;
      write_strobe <= busy_d && wr_d;
      chip_select_outputs <= ~((busy_d ? cs_d : CS_RESET) ^ cs_active_high);
      upper_byte_lane_enable <= busy_d && lanes_d[1];
      lower_byte_lane_enable <= busy_d && lanes_d[0];
    end
  end

  // ==========================================================
  // Data lanes
  // Upper lanes join the bus only in sixteen-bit mode.
  // Drive follows the write strobe cycle for cycle, so the lanes float otherwise.
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      lane_alt[i] = data_alt_en[i] && ext_enable && (bus_16bit || i < BYTE_W);
      lane_drive[i] = busy_d && wr_d;
    end
  end

  ebi_lane_mux u_lanes (
    .clk(clk),
    .resetn(resetn),
    .lane_alt(lane_alt),
    .lane_drive(lane_drive),
    .lane_out(wdata_d),
    .port_out(port_data_out),
    .port_oe(port_data_oe),
    .pin_out(data_out),
    .pin_oe(data_oe)
  );
endmodule : ebi_pins
`default_nettype wire

// File: dv/ebi_checker.sv
// Checker of the external bus pin timing.
`default_nettype none
module ebi_checker (
  // Clock, reset, configuration
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_enable,
  input wire logic exec_internal,
  input wire logic bus_16bit,
  input wire logic [23:0] addr_alt_en,
  input wire logic [5:0] cs_active_high,
  // Request and pins
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_lanes,
  input wire logic wait_in,
  input wire logic cpu_stall,
  input wire logic rsp_valid,
  input wire logic [23:0] addr_out,
  input wire logic [23:0] addr_oe,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [5:0] chip_select_outputs,
  input wire logic upper_byte_lane_enable,
  input wire logic lower_byte_lane_enable
);
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tk;
  // A request is taken only in idle, so busy cycles never look like a new start.
  assign tk = req_valid && !cpu_stall && !rsp_valid && ext_enable && !exec_internal;
  property p_addr_oe; $past(resetn) && $past(ext_enable) |-> &(addr_oe | ~$past(addr_alt_en));
  endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address pin not driven");
  property p_addr_zero; $past(resetn) && $past(ext_enable && exec_internal)
    |-> (addr_out & $past(addr_alt_en)) == 24'h000000; endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address not zero");
  property p_rd_start; tk && !req_write |=> cpu_stall && read_strobe && !write_strobe;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read strobe late");
  property p_wr_start; tk && req_write |=> cpu_stall && write_strobe && !read_strobe;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write strobe late");
  property p_rd_end; read_strobe && !wait_in |=> !read_strobe && rsp_valid && !cpu_stall;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read strobe overstays");
  property p_wait; (read_strobe || write_strobe) && wait_in |=> $stable({read_strobe,
    write_strobe}) && cpu_stall && !rsp_valid; endproperty
  a_wait: assert property (p_wait) else $error("wait not honoured");
  property p_cs_idle; $past(resetn) && !read_strobe && !write_strobe
    |-> chip_select_outputs == ~$past(cs_active_high); endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("select not inactive");
  property p_lanes; $rose(read_strobe || write_strobe) |-> {upper_byte_lane_enable,
    lower_byte_lane_enable} == ($past(bus_16bit) ? $past(req_lanes) : 2'h1); endproperty
  a_lanes: assert property (p_lanes) else $error("lane enables wrong");
endmodule : ebi_checker
bind ebi_pins ebi_checker ebi_checker_inst (.*);
`default_nettype wire

// File: dv/ebi_mem_model.sv
// External memory on the far side of the bus.
`default_nettype none
module ebi_mem_model (
  // Bus pins
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rd,
  input wire logic wr,
  input wire logic ube,
  input wire logic lbe,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0000;
  // Only the enabled byte lanes are stored.
  always_ff @(posedge clk) begin
    if (wr && ube) mem[addr[3:0]][15:8] <= wdata[15:8];
    if (wr && lbe) mem[addr[3:0]][7:0] <= wdata[7:0];
    last_q <= rdata;
  end
  // Released lines toggle, so stale data can never pass as a good read.
  assign rdata = rd ? mem[addr[3:0]] : ~last_q;
endmodule : ebi_mem_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench of the external bus pin interface.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, ext_enable = 1'b1, exec_internal = 1'b0, bus_16bit = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, wait_in = 1'b0, cpu_stall, rsp_valid;
  logic read_strobe, write_strobe, upper_byte_lane_enable, lower_byte_lane_enable;
  logic [23:0] addr_alt_en = 24'h00ffff, req_addr = 24'h000000, port_addr_out = 24'h000000;
  logic [23:0] port_addr_oe = 24'h000000, addr_out, addr_oe;
  logic [15:0] data_alt_en = 16'hffff, req_wdata = 16'h0000, port_data_out = 16'h0000;
  logic [15:0] port_data_oe = 16'h0000, rsp_rdata, data_in, data_out, data_oe, oe_mid;
  logic [5:0] cs_active_high = 6'h3c, req_cs = 6'h01, chip_select_outputs, cs_mid;
  logic [1:0] req_lanes = 2'b11;
  int failures = 0, num_checks = 0, cycles = 0;
  ebi_pins ebi_pins_inst (.*);
  ebi_mem_model ebi_mem_model_inst (.clk(clk), .addr(addr_out), .wdata(data_out),
    .rd(read_strobe), .wr(write_strobe), .ube(upper_byte_lane_enable),
    .lbe(lower_byte_lane_enable), .rdata(data_in));
  // Free-running clock of 25 ns.
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Ceiling on the run, in case a handshake never completes.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      summarize();
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One bus cycle; wait is held for w edges once the strobe is up.
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [1:0] ln,
      input logic [15:0] wd, input int w, output logic [15:0] rd, output int n);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_lanes = ln;
    req_wdata = wd;
    @(posedge clk);
    #2 req_valid = 1'b0;
    wait_in = (w > 0);
    cs_mid = chip_select_outputs;
    oe_mid = data_oe;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #2 n++;
      if (n > w) wait_in = 1'b0;
    end
    rd = rsp_rdata;
    @(posedge clk);
    #2;
  endtask : xfer
  task automatic t_rw16();
    logic [15:0] d;
    int n;
    xfer(1'b1, 24'h000005, 2'b11, 16'ha55a, 0, d, n);
    check(24'(n), 24'd2);
    check(24'(oe_mid), 24'h00ffff);
    check(24'(cs_mid), 24'h000002);
    xfer(1'b1, 24'h000005, 2'b10, 16'hbeef, 0, d, n);
    xfer(1'b0, 24'h000005, 2'b11, 16'h0000, 0, d, n);
    check(24'(d), 24'h00be5a);
  endtask : t_rw16
  task automatic t_wait();
    logic [15:0] d;
    int n;
    xfer(1'b0, 24'h000005, 2'b11, 16'h0000, 3, d, n);
    check(24'(n), 24'd5);
    check(24'(d), 24'h00be5a);
  endtask : t_wait
  task automatic t_bus8();
    logic [15:0] d;
    int n;
    bus_16bit = 1'b0;
    xfer(1'b1, 24'h000006, 2'b11, 16'h1234, 0, d, n);
    xfer(1'b0, 24'h000006, 2'b11, 16'h0000, 0, d, n);
    check(24'(d), 24'h000034);
    bus_16bit = 1'b1;
  endtask : t_bus8
  task automatic t_cs();
    logic [15:0] d;
    int n;
    cs_active_high = 6'h01;
    xfer(1'b0, 24'h000005, 2'b11, 16'h0000, 0, d, n);
    check(24'(cs_mid), 24'h00003f);
    check(24'(chip_select_outputs), 24'h00003e);
  endtask : t_cs
  task automatic t_pins();
    data_alt_en = 16'h00ff;
    port_data_oe = 16'hff00;
    repeat (2) @(posedge clk);
    #2 check(addr_oe, 24'h00ffff);
    check(24'(data_oe), 24'h00ff00);
    ext_enable = 1'b0;
    req_valid = 1'b1;
    repeat (3) @(posedge clk);
    #2 check(24'(cpu_stall), 24'h000000);
    check(addr_oe, 24'h000000);
    ext_enable = 1'b1;
    exec_internal = 1'b1;
    repeat (3) @(posedge clk);
    #2 check(addr_out, 24'h000000);
    check(24'(cpu_stall), 24'h000000);
    req_valid = 1'b0;
    exec_internal = 1'b0;
  endtask : t_pins
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    #2 resetn = 1'b1;
    t_rw16();
    t_wait();
    t_bus8();
    t_cs();
    t_pins();
    summarize();
  end
endmodule : tb
`default_nettype wire
